// ---- tcc_top.sv ----
`timescale 1ns/10ps
// Contract
// - Counter-select 1 counts falling edges of count pin, else system clock.
// - Prescaler divides timer input by 1, 2, 4 or 8.
// - Timer advances only while run bit is set.
// - Low byte overflow sets low flag; high overflow sets both flags.
// - Timer interrupt needs enable and a selected, set overflow flag.
// - Overflow flags stay set until software writes zero.
// - 16-bit reload register gives up/down auto-reload and clock output.
// - Selected edge on capture pin loads timer into its capture pair.
// - Edge bit 2n+1 selects falling, 2n rising, both give either.
// - Capture pins also serve as external interrupt inputs.
// - Same edge selection governs capture and external interrupt.
// - Qualifying capture edge sets event flag n, interrupt if enabled.
// - Compare after each step; match flag set one cycle later.
// - Compare pair 0 match sets port bits 5:0 where set-enabled.
// - Compare pair 1 match clears port bits 5:0 where clear-enabled.
// - Compare pair 2 match inverts toggle flops driving port bits 7:6.
// - Zero enable bits leave the port pin untouched by matches.
module tcc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic external_count_pin_i,
   input wire logic [3:0] capture_input_i,
   output logic [7:0] port_o,
   output logic timer_clk_o,
   output logic irq_o
);
   logic [4:0] s1_ff, s2_ff, prev_ff;
   logic [4:0] rise, fall;
   logic [2:0] ctrl_ff;
   logic [7:0] tsel_ff;
   logic hovf_ff, lovf_ff;
   logic [15:0] timer_ff, reload_ff;
   logic [2:0] pre_ff;
   logic [2:0] pre_mask;
   logic [7:0] ces_ff, seten_ff, clren_ff, irqen_ff;
   logic [6:0] evf_ff;
   logic [15:0] cap_ff [tcc_pkg::CAP_N];
   logic [15:0] cmp_ff [tcc_pkg::CMP_N];
   logic [5:0] latch_ff;
   logic [1:0] tog_ff;
   logic tick_d_ff;
   logic [3:0] cap_evt;
   logic [2:0] match;
   logic acc, wr;
   logic wr_ctrl, wr_sel, wr_timer, wr_rel, wr_evf, wr_port;
   logic src_evt, tick, ovf, lovf_evt, down;
   logic timer_irq;
   logic [31:0] rdata;

   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [31:0] d, input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Bus decode: one wait state, ack drops the cycle after
   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = acc && wb_we_i;
   assign wr_ctrl = wr && wb_sel_i[0] && wb_adr_i == tcc_pkg::A_CTRL;
   assign wr_sel = wr && wb_sel_i[0] && wb_adr_i == tcc_pkg::A_SEL;
   assign wr_timer = wr && wb_adr_i == tcc_pkg::A_TIMER;
   assign wr_rel = wr && wb_adr_i == tcc_pkg::A_RELOAD;
   assign wr_evf = wr && wb_sel_i[0] && wb_adr_i == tcc_pkg::A_EVF;
   assign wr_port = wr && wb_sel_i[0] && wb_adr_i == tcc_pkg::A_PORT;

   // First stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_ff <= 5'h00;
         s2_ff <= 5'h00;
         prev_ff <= 5'h00;
      end else begin
         s1_ff <= {external_count_pin_i, capture_input_i};
         s2_ff <= s1_ff;
         prev_ff <= s2_ff;
      end
   end
   assign rise = s2_ff & ~prev_ff;
   assign fall = ~s2_ff & prev_ff;

   // Edge bits govern capture and external interrupt alike
   genvar g;
   generate
      for (g = 0; g < tcc_pkg::CAP_N; g++) begin : g_cap
         assign cap_evt[g] = (rise[g] && ces_ff[2*g]) ||
            (fall[g] && ces_ff[2*g+1]);
      end
   endgenerate

   // Timer source, prescaler and run gate
   assign down = ctrl_ff[tcc_pkg::CTRL_DOWN];
   assign src_evt = ctrl_ff[tcc_pkg::CTRL_CSEL] ? fall[4] : 1'b1;
   always_comb begin
      unique case (tsel_ff[1:0])
         2'h0: pre_mask = 3'h0;
         2'h1: pre_mask = 3'h1;
         2'h2: pre_mask = 3'h3;
         2'h3: pre_mask = 3'h7;
      endcase
   end
   assign tick = src_evt && ctrl_ff[tcc_pkg::CTRL_RUN] &&
      (pre_ff & pre_mask) == pre_mask;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_ff <= tcc_pkg::PRE_ZERO;
      end else if (!ctrl_ff[tcc_pkg::CTRL_RUN]) begin
         pre_ff <= tcc_pkg::PRE_ZERO;
      end else if (src_evt) begin
         pre_ff <= (pre_ff + 3'h1) & pre_mask;
      end
   end

   // Wrap at top (up) or at reload value (down)
   assign ovf = tick && (down ? timer_ff == reload_ff :
      timer_ff == tcc_pkg::TOP_WORD);
   assign lovf_evt = ovf || (tick && (down ?
      timer_ff[7:0] == tcc_pkg::RST_BYTE :
      timer_ff[7:0] == tcc_pkg::TOP_BYTE));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_ff <= tcc_pkg::RST_WORD;
      end else if (wr_timer) begin
         timer_ff <= merge16(timer_ff, wb_dat_i, wb_sel_i);
      end else if (ovf) begin
         timer_ff <= down ? tcc_pkg::TOP_WORD : reload_ff;
      end else if (tick) begin
         timer_ff <= down ? timer_ff - 16'h0001 :
            timer_ff + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_ff <= tcc_pkg::RST_WORD;
         timer_clk_o <= 1'b0;
      end else begin
         if (wr_rel) begin
            reload_ff <= merge16(reload_ff, wb_dat_i, wb_sel_i);
         end
         if (ovf) begin
            timer_clk_o <= !timer_clk_o;
         end
      end
   end

   // Overflow flags: set wins, only a written zero clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= tcc_pkg::PRE_ZERO;
         tsel_ff <= tcc_pkg::RST_BYTE;
         hovf_ff <= 1'b0;
         lovf_ff <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wb_dat_i[2:0];
            hovf_ff <= ovf || wb_dat_i[tcc_pkg::CTRL_HOVF];
         end else begin
            hovf_ff <= ovf || hovf_ff;
         end
         if (wr_sel) begin
            tsel_ff <= {wb_dat_i[7:6], 2'h0, 2'h0, wb_dat_i[1:0]};
            lovf_ff <= lovf_evt || wb_dat_i[tcc_pkg::SEL_LOVF] ||
               (wr_ctrl && wb_dat_i[tcc_pkg::CTRL_HOVF]);
         end else begin
            lovf_ff <= lovf_evt || lovf_ff ||
               (wr_ctrl && wb_dat_i[tcc_pkg::CTRL_HOVF]);
         end
      end
   end

   // Capture pairs and compare pairs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < tcc_pkg::CAP_N; i++) begin
            cap_ff[i] <= tcc_pkg::RST_WORD;
         end
      end else begin
         for (int i = 0; i < tcc_pkg::CAP_N; i++) begin
            if (cap_evt[i]) begin
               cap_ff[i] <= timer_ff;
            end
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < tcc_pkg::CMP_N; i++) begin
            cmp_ff[i] <= tcc_pkg::RST_WORD;
         end
      end else begin
         for (int i = 0; i < tcc_pkg::CMP_N; i++) begin
            if (wr && wb_adr_i == tcc_pkg::A_CMP0 + 8'(4 * i)) begin
               cmp_ff[i] <= merge16(cmp_ff[i], wb_dat_i, wb_sel_i);
            end
         end
      end
   end

   // Compare only on the cycle after a step
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_d_ff <= 1'b0;
      end else begin
         tick_d_ff <= tick;
      end
   end
   generate
      for (g = 0; g < tcc_pkg::CMP_N; g++) begin : g_cmp
         assign match[g] = tick_d_ff && timer_ff == cmp_ff[g];
      end
   endgenerate

   // Enable registers; upper set-enable bits read back the toggle flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ces_ff <= tcc_pkg::RST_BYTE;
         seten_ff <= tcc_pkg::RST_BYTE;
         clren_ff <= tcc_pkg::RST_BYTE;
         irqen_ff <= tcc_pkg::RST_BYTE;
      end else if (wr && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            tcc_pkg::A_CES: ces_ff <= wb_dat_i[7:0];
            tcc_pkg::A_SETEN: seten_ff <= wb_dat_i[7:0];
            tcc_pkg::A_CLREN: clren_ff <= wb_dat_i[7:0];
            tcc_pkg::A_IRQEN: irqen_ff <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // Sticky event flags, write one to clear, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evf_ff <= 7'h00;
      end else begin
         evf_ff <= (evf_ff & ~(wr_evf ? wb_dat_i[6:0] : 7'h00)) |
            {match, cap_evt};
      end
   end

   // Port: set then clear, clear wins on a tie
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_ff <= 6'h00;
         tog_ff <= 2'h0;
      end else begin
         latch_ff <= ((wr_port ? wb_dat_i[5:0] : latch_ff) |
            (match[0] ? seten_ff[5:0] : 6'h00)) &
            ~(match[1] ? clren_ff[5:0] : 6'h00);
         if (match[2]) begin
            tog_ff <= tog_ff ^ clren_ff[7:6];
         end
      end
   end
   assign port_o = {tog_ff, latch_ff};

   assign timer_irq = irqen_ff[tcc_pkg::IRQEN_TMR] &&
      ((lovf_ff && tsel_ff[tcc_pkg::SEL_LSEL]) ||
      (hovf_ff && tsel_ff[tcc_pkg::SEL_HSEL]));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= timer_irq || |(evf_ff & irqen_ff[6:0]);
      end
   end
   always_comb begin
      rdata = tcc_pkg::RD_NONE;
      unique case (wb_adr_i)
         tcc_pkg::A_CTRL: rdata[7:0] = {hovf_ff, 4'h0, ctrl_ff};
         tcc_pkg::A_SEL: rdata[7:0] = {tsel_ff[7:6], 1'b0, lovf_ff,
            2'h0, tsel_ff[1:0]};
         tcc_pkg::A_TIMER: rdata[15:0] = timer_ff;
         tcc_pkg::A_RELOAD: rdata[15:0] = reload_ff;
         tcc_pkg::A_CES: rdata[7:0] = ces_ff;
         tcc_pkg::A_SETEN: rdata[7:0] = {tog_ff, seten_ff[5:0]};
         tcc_pkg::A_CLREN: rdata[7:0] = clren_ff;
         tcc_pkg::A_EVF: rdata[6:0] = evf_ff;
         tcc_pkg::A_IRQEN: rdata[7:0] = irqen_ff;
         tcc_pkg::A_CAP0: rdata[15:0] = cap_ff[0];
         tcc_pkg::A_CAP1: rdata[15:0] = cap_ff[1];
         tcc_pkg::A_CAP2: rdata[15:0] = cap_ff[2];
         tcc_pkg::A_CAP3: rdata[15:0] = cap_ff[3];
         tcc_pkg::A_CMP0: rdata[15:0] = cmp_ff[0];
         tcc_pkg::A_CMP1: rdata[15:0] = cmp_ff[1];
         tcc_pkg::A_CMP2: rdata[15:0] = cmp_ff[2];
         tcc_pkg::A_PORT: rdata[7:0] = port_o;
         default: rdata = tcc_pkg::RD_NONE;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= tcc_pkg::RD_NONE;
      end else begin
         wb_ack_o <= acc;
         if (acc && !wb_we_i) begin
            wb_dat_o <= rdata;
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence count_edge_s;
      ctrl_ff[tcc_pkg::CTRL_CSEL] && ctrl_ff[tcc_pkg::CTRL_RUN] &&
         tsel_ff[1:0] == 2'h0 && !down && fall[4] && !wr_timer &&
         timer_ff != tcc_pkg::TOP_WORD;
   endsequence
   sequence step_then_hit_s;
      tick && !wr_timer ##1 timer_ff == cmp_ff[0];
   endsequence
   ext_count_a: assert property (count_edge_s |=>
      timer_ff == $past(timer_ff) + 16'h0001)
      else $error("count pin edge did not advance timer");
   no_edge_hold_a: assert property (ctrl_ff[tcc_pkg::CTRL_CSEL] &&
      !fall[4] && !wr_timer |=> $stable(timer_ff))
      else $error("timer moved without count pin edge");
   run_stop_a: assert property (!ctrl_ff[tcc_pkg::CTRL_RUN] &&
      !wr_timer |=> timer_ff == $past(timer_ff))
      else $error("timer advanced while stopped");
   high_sets_low_a: assert property ($rose(hovf_ff) |-> lovf_ff)
      else $error("high overflow without low overflow");
   timer_irq_a: assert property (timer_irq |=> irq_o)
      else $error("timer interrupt not raised");
   irq_gate_a: assert property (!timer_irq &&
      (evf_ff & irqen_ff[6:0]) == 7'h00 |=> !irq_o)
      else $error("interrupt raised without cause");
   flag_sticky_a: assert property (hovf_ff && !wr_ctrl |=> hovf_ff)
      else $error("overflow flag cleared by hardware");
   capture_load_a: assert property (cap_evt[0] |=>
      cap_ff[0] == $past(timer_ff) && evf_ff[0])
      else $error("capture did not load timer value");
   edge_off_a: assert property (ces_ff[1:0] == 2'h0 |->
      !cap_evt[0]) else $error("disabled channel triggered");
   cmp_flag_a: assert property (step_then_hit_s |=>
      evf_ff[tcc_pkg::EV_CMP])
      else $error("compare flag not set after match");
   set_port_a: assert property (match[0] && !match[1] &&
      seten_ff[0] |=> port_o[0])
      else $error("set on match failed");
   clear_port_a: assert property (match[1] && clren_ff[1] |=>
      !port_o[1]) else $error("clear on match failed");
   toggle_a: assert property (match[2] && clren_ff[tcc_pkg::TOG_LO]
      |=> port_o[6] != $past(port_o[6]))
      else $error("toggle flop did not invert");
   untouched_a: assert property (match[2] &&
      !clren_ff[tcc_pkg::TOG_LO] |=> $stable(port_o[6]))
      else $error("toggle without enable");
endmodule

// ---- tcc_pkg.sv ----
package tcc_pkg;
   // Byte addresses on the Wishbone slave
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_SEL = 8'h04;
   localparam logic [7:0] A_TIMER = 8'h08;
   localparam logic [7:0] A_RELOAD = 8'h0C;
   localparam logic [7:0] A_CES = 8'h10;
   localparam logic [7:0] A_SETEN = 8'h14;
   localparam logic [7:0] A_CLREN = 8'h18;
   localparam logic [7:0] A_EVF = 8'h1C;
   localparam logic [7:0] A_IRQEN = 8'h20;
   localparam logic [7:0] A_CAP0 = 8'h24;
   localparam logic [7:0] A_CAP1 = 8'h28;
   localparam logic [7:0] A_CAP2 = 8'h2C;
   localparam logic [7:0] A_CAP3 = 8'h30;
   localparam logic [7:0] A_CMP0 = 8'h34;
   localparam logic [7:0] A_CMP1 = 8'h38;
   localparam logic [7:0] A_CMP2 = 8'h3C;
   localparam logic [7:0] A_PORT = 8'h40;
   localparam int CAP_N = 4;
   localparam int CMP_N = 3;
   // Field positions
   localparam int CTRL_HOVF = 7;
   localparam int CTRL_RUN = 2;
   localparam int CTRL_CSEL = 1;
   localparam int CTRL_DOWN = 0;
   localparam int SEL_HSEL = 7;
   localparam int SEL_LSEL = 6;
   localparam int SEL_LOVF = 4;
   localparam int IRQEN_TMR = 7;
   localparam int EV_CMP = 4;
   localparam int TOG_LO = 6;
   // Reset and limit values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] TOP_WORD = 16'hFFFF;
   localparam logic [7:0] TOP_BYTE = 8'hFF;
   localparam logic [2:0] PRE_ZERO = 3'h0;
   localparam logic [31:0] RD_NONE = 32'h0000_0000;
endpackage

// ---- tcc_pins.sv ----
`timescale 1ns/10ps
module tcc_pins (
   input wire logic clk_i,
   output logic count_o,
   output logic [3:0] cap_o
);
   initial begin
      count_o = 1'b0;
      cap_o = 4'h0;
   end
   // Levels held several clocks so the pin sampler cannot miss them
   task automatic set_caps(input logic [3:0] v);
      @(posedge clk_i);
      cap_o <= v;
      repeat (8) @(posedge clk_i);
   endtask
   task automatic count_pulses(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         count_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         count_o <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask
endmodule

// ---- tcc_top_tb.sv ----
`timescale 1ns/10ps
module tcc_top_tb;
   logic clk_i, rst_i, cyc, stb, we, wb_ack_o;
   logic count_pin, timer_clk_o, irq_o;
   logic [7:0] adr, port_o;
   logic [3:0] sel, caps;
   logic [31:0] dat, wb_dat_o, q, t0;
   int miscompares = 0;
   int num_checks = 0;
   tcc_top tcc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .external_count_pin_i(count_pin), .capture_input_i(caps),
      .port_o(port_o), .timer_clk_o(timer_clk_o), .irq_o(irq_o));
   tcc_pins tcc_pins_i (.clk_i(clk_i), .count_o(count_pin), .cap_o(caps));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic give_verdict;
      $display("Checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [31:0] got, input int lo, hi);
      num_checks++;
      if ($isunknown(got) || got < lo || got > hi) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, lo);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   // Irq is registered one cycle behind its cause
   task automatic irq_is(input logic [31:0] e);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, e);
   endtask
   task automatic t_regs;
      logic [7:0] ra [8];
      ra = '{tcc_pkg::A_CTRL, tcc_pkg::A_SEL, tcc_pkg::A_CES,
         tcc_pkg::A_SETEN, tcc_pkg::A_CLREN, tcc_pkg::A_EVF,
         tcc_pkg::A_IRQEN, tcc_pkg::A_PORT};
      foreach (ra[i]) rd_chk(ra[i], 32'h0000_0000);
      chk({24'h0, port_o}, 32'h0000_0000);
      wr(8'h44, 32'hFFFF_FFFF);
      rd_chk(8'h44, 32'h0000_0000);
      wr(tcc_pkg::A_CES, 32'h0000_00A5);
      rd_chk(tcc_pkg::A_CES, 32'h0000_00A5);
   endtask
   task automatic t_prescale;
      for (int p = 0; p < 4; p++) begin
         wr(tcc_pkg::A_TIMER, 32'h0000_0000);
         wr(tcc_pkg::A_SEL, p);
         wr(tcc_pkg::A_CTRL, 32'h0000_0004);
         repeat (62) @(posedge clk_i);
         wr(tcc_pkg::A_CTRL, 32'h0000_0000);
         wb(1'b0, tcc_pkg::A_TIMER, 32'h0000_0000);
         t0 = q;
         chk_rng(t0, (60 >> p) - 1, (68 >> p) + 1);
         repeat (10) @(posedge clk_i);
         rd_chk(tcc_pkg::A_TIMER, t0);
      end
   endtask
   task automatic t_count;
      wr(tcc_pkg::A_SEL, 32'h0000_0000);
      wr(tcc_pkg::A_TIMER, 32'h0000_0000);
      wr(tcc_pkg::A_CTRL, 32'h0000_0006);
      repeat (20) @(posedge clk_i);
      tcc_pins_i.count_pulses(5);
      wr(tcc_pkg::A_CTRL, 32'h0000_0000);
      rd_chk(tcc_pkg::A_TIMER, 32'h0000_0005);
   endtask
   task automatic t_overflow;
      wr(tcc_pkg::A_RELOAD, 32'h0000_1234);
      wr(tcc_pkg::A_TIMER, 32'h0000_FFF0);
      wr(tcc_pkg::A_SEL, 32'h0000_0080);
      wr(tcc_pkg::A_IRQEN, 32'h0000_0080);
      irq_is(32'h0000_0000);
      wr(tcc_pkg::A_CTRL, 32'h0000_0004);
      repeat (40) @(posedge clk_i);
      rd_chk(tcc_pkg::A_CTRL, 32'h0000_0084);
      rd_chk(tcc_pkg::A_SEL, 32'h0000_0090);
      wb(1'b0, tcc_pkg::A_TIMER, 32'h0000_0000);
      chk_rng(q, 32'h1234, 32'h1274);
      chk({31'h0, timer_clk_o}, 32'h0000_0001);
      irq_is(32'h0000_0001);
      wr(tcc_pkg::A_IRQEN, 32'h0000_0000);
      irq_is(32'h0000_0000);
      wr(tcc_pkg::A_IRQEN, 32'h0000_0080);
      irq_is(32'h0000_0001);
      wr(tcc_pkg::A_CTRL, 32'h0000_0000);
      irq_is(32'h0000_0000);
      wr(tcc_pkg::A_SEL, 32'h0000_00D0);
      irq_is(32'h0000_0001);
      wr(tcc_pkg::A_SEL, 32'h0000_0000);
      irq_is(32'h0000_0000);
   endtask
   task automatic t_capture;
      wr(tcc_pkg::A_EVF, 32'h0000_007F);
      wr(tcc_pkg::A_TIMER, 32'h0000_0100);
      wr(tcc_pkg::A_CES, 32'h0000_0039);
      wr(tcc_pkg::A_IRQEN, 32'h0000_0002);
      tcc_pins_i.set_caps(4'hF);
      rd_chk(tcc_pkg::A_EVF, 32'h0000_0005);
      irq_is(32'h0000_0000);
      tcc_pins_i.set_caps(4'h0);
      rd_chk(tcc_pkg::A_EVF, 32'h0000_0007);
      irq_is(32'h0000_0001);
      rd_chk(tcc_pkg::A_CAP0, 32'h0000_0100);
      rd_chk(tcc_pkg::A_CAP0 + 8'h04, 32'h0000_0100);
      rd_chk(tcc_pkg::A_CAP0 + 8'h0C, 32'h0000_0000);
      wr(tcc_pkg::A_EVF, 32'h0000_0007);
      rd_chk(tcc_pkg::A_EVF, 32'h0000_0000);
      irq_is(32'h0000_0000);
   endtask
   task automatic t_compare;
      wr(tcc_pkg::A_SETEN, 32'h0000_000F);
      wr(tcc_pkg::A_CLREN, 32'h0000_00C3);
      wr(tcc_pkg::A_CMP0, 32'h0000_0010);
      wr(tcc_pkg::A_CMP0 + 8'h04, 32'h0000_0020);
      wr(tcc_pkg::A_CMP0 + 8'h08, 32'h0000_0030);
      wr(tcc_pkg::A_IRQEN, 32'h0000_0010);
      wr(tcc_pkg::A_TIMER, 32'h0000_0000);
      wr(tcc_pkg::A_CTRL, 32'h0000_0004);
      repeat (70) @(posedge clk_i);
      wr(tcc_pkg::A_CTRL, 32'h0000_0000);
      chk({24'h0, port_o}, 32'h0000_00CC);
      rd_chk(tcc_pkg::A_EVF, 32'h0000_0070);
      rd_chk(tcc_pkg::A_SETEN, 32'h0000_00CF);
      irq_is(32'h0000_0001);
   endtask
   // Outputs are set beforehand so a missed reset shows
   task automatic t_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({24'h0, port_o}, 32'h0000_0000);
      chk({30'h0, timer_clk_o, irq_o}, 32'h0000_0000);
      rd_chk(tcc_pkg::A_CTRL, 32'h0000_0000);
   endtask
   task automatic t_down;
      wr(tcc_pkg::A_RELOAD, 32'h0000_0010);
      wr(tcc_pkg::A_TIMER, 32'h0000_0014);
      wr(tcc_pkg::A_CTRL, 32'h0000_0005);
      repeat (20) @(posedge clk_i);
      rd_chk(tcc_pkg::A_CTRL, 32'h0000_0085);
      rd_chk(tcc_pkg::A_SEL, 32'h0000_0010);
      wb(1'b0, tcc_pkg::A_TIMER, 32'h0000_0000);
      chk_rng(q, 32'hFFE0, 32'hFFFE);
      chk({31'h0, timer_clk_o}, 32'h0000_0001);
      wr(tcc_pkg::A_CTRL, 32'h0000_0000);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      give_verdict();
   end
   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hF;
      dat = 32'h0000_0000;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_prescale();
      t_count();
      t_overflow();
      t_capture();
      t_compare();
      t_reset();
      t_down();
      give_verdict();
   end
endmodule
